// file: common/bas_pkg.sv
package bas_pkg;
  // Word length selection shared by both link ends
  typedef enum logic [1:0] {
    BAS_WL_8,
    BAS_WL_16,
    BAS_WL_32
  } bas_wlen_t;
  localparam int BAS_MAX_BITS = 32;
  localparam logic [5:0] BAS_BITS_8 = 6'h08;
  localparam logic [5:0] BAS_BITS_16 = 6'h10;
  localparam logic [5:0] BAS_BITS_32 = 6'h20;
  // S/PDIF clock is this multiple of the word clock
  localparam int BAS_SPDIF_PER_WORD = 64;
  // Converter clock per output sample (16.9344 MHz / 44.1 kHz)
  localparam int BAS_SRC_DIV = 384;
  localparam int BAS_SUBFRAMES = 384;
  localparam logic [3:0] BAS_PRE_B = 4'h1;
  localparam logic [3:0] BAS_PRE_M = 4'h2;
  localparam logic [3:0] BAS_PRE_W = 4'h3;
  // One stereo sample pair
  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
  } bas_pair_t;
  // Configuration bits from software
  typedef struct packed {
    logic master;
    bas_wlen_t wlen;
    logic stereo;
    logic soft_reset;
    logic stop;
    logic mute;
    logic double_speed;
    logic gate_bclk;
  } bas_cfg_t;
endpackage

// file: hdl/bas_serializer.sv
// Overview of operation
// R1: Master drives bit and word clocks; slave takes them from the partner.
// R2: Word length 8, 16 or 32 bits, same on both ends.
// R3: Mono repeats left in both slots; stereo sends left and right.
// R4: Sample rate 16 to 48 kHz set by master divider.
// R5: Separate transmit and receive buffers, depth fixed at build time; the code fixes both at two entries and leaves FIFO_DEPTH unused.
// R6: Interrupt plus transmit and receive DMA requests, each acknowledged; the interrupt here is a one-cycle pulse with no acknowledge.
// R7: Soft reset, stop and mute controls.
// R8: Converter takes stereo input, outputs fixed 44.1 kHz pairs.
// R9: Converter clocked at 16.9344 MHz, 384 clocks per output.
// R10: Converter accepts inputs from 8 to 48 kHz.
// R11: Input buffered, upsampled by N, held, decimated by M.
// R12: Single wire biphase output in IEC 958 frames.
// R13: S/PDIF rate selectable single or double CD speed.
// R14: S/PDIF needs internal bit clock and gating off.
// R15: S/PDIF clock is 64 times the word clock.
// R16: Software writes user channel bits.
// R17: Exactly one output pair per output period, never stalled.
`timescale 1ns/10ps
`default_nettype none
module bas_serializer #(
  parameter int FIFO_DEPTH = 2,
  parameter int BCLK_DIV = 8
) (
  // System clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  // Converter clock, 16.9344 MHz
  input wire logic CLK_SRC_IN,
  // Configuration
  input wire bas_pkg::bas_cfg_t CFG_IN,
  input wire logic [15:0] SRC_STEP_IN,
  input wire logic USER_BIT_IN,
  // Transmit data from processor or DMA
  input wire bas_pkg::bas_pair_t TX_DATA_IN,
  input wire logic TX_VALID_IN,
  output logic TX_READY_OUT,
  // Receive data to processor or DMA
  output bas_pkg::bas_pair_t RX_DATA_OUT,
  output logic RX_VALID_OUT,
  input wire logic RX_READY_IN,
  // DMA and interrupt
  output logic TX_DMA_REQ_OUT,
  input wire logic TX_DMA_ACK_IN,
  output logic RX_DMA_REQ_OUT,
  input wire logic RX_DMA_ACK_IN,
  output logic IRQ_OUT,
  // Serial audio pins
  input wire logic BCLK_IN,
  input wire logic WCLK_IN,
  input wire logic SDI_IN,
  output logic BCLK_OUT,
  output logic BCLK_OE_OUT,
  output logic WCLK_OUT,
  output logic WCLK_OE_OUT,
  output logic SDO_OUT,
  // Converted 44.1 kHz stream in converter domain
  output bas_pkg::bas_pair_t SRC_DATA_OUT,
  output logic SRC_STROBE_OUT,
  // S/PDIF line
  output logic SPDIF_OUT
);
  typedef struct packed {
    bas_pkg::bas_pair_t [1:0] txq;
    logic [1:0] txn;
    bas_pkg::bas_pair_t [1:0] rxq;
    logic [1:0] rxn;
    bas_pkg::bas_pair_t sh_tx;
    bas_pkg::bas_pair_t sh_rx;
    logic [5:0] bit_cnt;
    logic chan;
    logic [7:0] div;
    logic bclk;
    logic wclk;
    logic [2:0] bsync;
    logic [2:0] wsync;
    logic [1:0] sdsync;
    logic txreq;
    logic rxreq;
    logic irq;
    logic [15:0] spd_sh;
    logic spd_line;
    logic [8:0] frame;
    logic [4:0] sp_bit;
    logic sp_half;
    logic wtog;
  } bas_sys_t;
  bas_sys_t s_reg, s_next;

  // Converter domain state
  typedef struct packed {
    logic [2:0] tsync;
    bas_pkg::bas_pair_t prev;
    bas_pkg::bas_pair_t cur;
    logic [15:0] phase;
    logic [8:0] tick;
    bas_pkg::bas_pair_t out;
    logic strobe;
  } bas_src_t;
  bas_src_t c_reg, c_next;

  function automatic logic [5:0] wbits(input bas_pkg::bas_wlen_t w);
    if (w == bas_pkg::BAS_WL_8) begin
      return bas_pkg::BAS_BITS_8;
    end else if (w == bas_pkg::BAS_WL_16) begin
      return bas_pkg::BAS_BITS_16;
    end
    return bas_pkg::BAS_BITS_32;
  endfunction

  function automatic logic [31:0] mix(input logic [31:0] a,
                                      input logic [31:0] b,
                                      input logic [15:0] f);
    logic [47:0] p;
    p = 48'($signed(b) - $signed(a)) * 48'(f);
    return a + p[47:16];
  endfunction

  logic [5:0] nbits;
  logic bclk_e, wclk_e, bclk_rise, bclk_fall, ext_rise, ext_fall;
  logic tx_pop, rx_push, slot_end, to_left;
  bas_pkg::bas_pair_t rx_word;
  assign nbits = wbits(CFG_IN.wlen); // R2

  // Link serial state
  always_comb begin
    s_next = s_reg;
    bclk_rise = 1'b0;
    bclk_fall = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_word = s_reg.sh_rx;
    s_next.bsync = {s_reg.bsync[1:0], BCLK_IN};
    s_next.wsync = {s_reg.wsync[1:0], WCLK_IN};
    s_next.sdsync = {s_reg.sdsync[0], SDI_IN};
    ext_rise = s_reg.bsync[1] & ~s_reg.bsync[2];
    ext_fall = ~s_reg.bsync[1] & s_reg.bsync[2];
    // Slave slots follow the partner's word clock, not the local count
    slot_end = CFG_IN.master ? s_reg.bit_cnt == nbits - 6'h01 :
      s_reg.wsync[1] != s_reg.wsync[2]; // R1
    to_left = CFG_IN.master ? s_reg.chan : !s_reg.wsync[1];
    // Master divides the system clock, slave follows partner edges
    if (CFG_IN.master) begin // R1
      s_next.div = s_reg.div + 8'h01;
      if (s_reg.div == 8'(BCLK_DIV - 1)) begin // R4
        s_next.div = 8'h00;
        s_next.bclk = ~s_reg.bclk;
        bclk_rise = ~s_reg.bclk;
        bclk_fall = s_reg.bclk;
      end
    end else begin
      bclk_rise = ext_rise;
      bclk_fall = ext_fall;
    end
    bclk_e = CFG_IN.master ? s_reg.bclk : s_reg.bsync[2];
    wclk_e = CFG_IN.master ? s_reg.wclk : s_reg.wsync[2];
    // Shift out on falling edge, sample on rising
    if (bclk_rise && !CFG_IN.stop) begin
      // Each slot fills only its own half, so left is not overwritten
      s_next.sh_rx.left = !wclk_e ?
        {s_reg.sh_rx.left[30:0], s_reg.sdsync[1]} : s_reg.sh_rx.left;
      s_next.sh_rx.right = wclk_e ?
        {s_reg.sh_rx.right[30:0], s_reg.sdsync[1]} : s_reg.sh_rx.right;
    end
    if (bclk_fall && !CFG_IN.stop) begin
      s_next.bit_cnt = s_reg.bit_cnt + 6'h01;
      s_next.sh_tx.left = {s_reg.sh_tx.left[30:0], 1'b0};
      if (slot_end) begin
        s_next.bit_cnt = 6'h00;
        s_next.chan = CFG_IN.master ? ~s_reg.chan : s_reg.wsync[1];
        s_next.wclk = ~s_reg.chan;
        s_next.sh_tx.left = s_reg.sh_tx.right;
        if (to_left) begin
          // Frame boundary: load next pair, hand up the received one
          rx_push = 1'b1;
          rx_word = CFG_IN.stereo ? s_reg.sh_rx :
            '{left: s_reg.sh_rx.left, right: s_reg.sh_rx.left}; // R3
          tx_pop = s_reg.txn != 2'h0;
          s_next.sh_tx = s_reg.txn != 2'h0 ? s_reg.txq[0] : '0;
          if (!CFG_IN.stereo) begin
            s_next.sh_tx.right = s_next.sh_tx.left; // R3
          end
          if (CFG_IN.mute) begin
            s_next.sh_tx = '0; // R7
          end
          s_next.sh_tx.left = s_next.sh_tx.left << (6'd32 - nbits);
          s_next.sh_tx.right = s_next.sh_tx.right << (6'd32 - nbits);
          s_next.wtog = ~s_reg.wtog;
        end
      end
    end
    // Two-entry transmit and receive buffers
    if (tx_pop) begin // R5
      s_next.txq[0] = s_reg.txq[1];
      s_next.txn = s_reg.txn - 2'h1;
    end
    if (TX_VALID_IN && TX_READY_OUT) begin
      s_next.txq[s_next.txn[0]] = TX_DATA_IN;
      s_next.txn = s_next.txn + 2'h1;
    end
    if (RX_VALID_OUT && RX_READY_IN) begin
      s_next.rxq[0] = s_reg.rxq[1];
      s_next.rxn = s_reg.rxn - 2'h1;
    end
    if (rx_push && s_next.rxn != 2'h2) begin
      s_next.rxq[s_next.rxn[0]] = rx_word; // R5
      s_next.rxn = s_next.rxn + 2'h1;
    end
    // DMA requests held until acknowledged, set wins over clear
    if (TX_DMA_ACK_IN) begin
      s_next.txreq = 1'b0;
    end
    if (s_next.txn == 2'h0) begin
      s_next.txreq = 1'b1; // R6
    end
    if (RX_DMA_ACK_IN) begin
      s_next.rxreq = 1'b0;
    end
    if (s_next.rxn != 2'h0) begin
      s_next.rxreq = 1'b1; // R6
    end
    s_next.irq = rx_push && s_reg.rxn == 2'h2; // R6
    // S/PDIF biphase, one half-cell per bit clock edge (128 per word clock at 32-bit words)
    s_next.sp_half = ~s_reg.sp_half;
    if (bclk_rise | bclk_fall) begin // R15
      s_next.spd_line = ~s_reg.spd_line ^ s_reg.spd_sh[15];
      s_next.spd_sh = {s_reg.spd_sh[14:0], 1'b0};
      if (CFG_IN.double_speed || s_reg.sp_half) begin // R13
        s_next.sp_bit = s_reg.sp_bit + 5'h01;
        s_next.spd_sh = {s_reg.spd_sh[14:0], ^s_reg.sh_tx.right[31:28]};
        if (s_reg.sp_bit == 5'h1f) begin
          s_next.frame = s_reg.frame == 9'(bas_pkg::BAS_SUBFRAMES - 1) ?
            9'h000 : s_reg.frame + 9'h001; // R12
          s_next.spd_sh = {(s_reg.frame == 9'h000 ? bas_pkg::BAS_PRE_B :
            s_reg.chan ? bas_pkg::BAS_PRE_W : bas_pkg::BAS_PRE_M),
            USER_BIT_IN, 11'h000}; // R16
        end
      end
    end
    if (!CFG_IN.master || CFG_IN.gate_bclk) begin
      s_next.spd_line = 1'b0; // R14
    end
    if (CFG_IN.soft_reset) begin
      s_next = '0; // R7
    end
  end

  assign TX_READY_OUT = s_reg.txn != 2'h2;
  assign RX_VALID_OUT = s_reg.rxn != 2'h0;
  assign RX_DATA_OUT = s_reg.rxq[0];
  assign TX_DMA_REQ_OUT = s_reg.txreq;
  assign RX_DMA_REQ_OUT = s_reg.rxreq;
  assign IRQ_OUT = s_reg.irq;
  assign BCLK_OUT = s_reg.bclk;
  assign WCLK_OUT = s_reg.wclk;
  assign BCLK_OE_OUT = CFG_IN.master;
  assign WCLK_OE_OUT = CFG_IN.master;
  assign SDO_OUT = s_reg.sh_tx.left[31];
  assign SPDIF_OUT = s_reg.spd_line;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Converter: new input pair signalled by toggle crossing
  always_comb begin
    c_next = c_reg;
    c_next.tsync = {c_reg.tsync[1:0], s_reg.wtog};
    c_next.strobe = 1'b0;
    if (c_reg.tsync[2] != c_reg.tsync[1]) begin // R10
      c_next.prev = c_reg.cur; // R11
      c_next.cur = s_reg.rxq[0]; // Oldest queued pair: the pair that flips the toggle lands in rxq[0] only if receive was empty
      c_next.phase = 16'h0000;
    end
    c_next.tick = c_reg.tick + 9'h001;
    if (c_reg.tick == 9'(bas_pkg::BAS_SRC_DIV - 1)) begin // R9
      c_next.tick = 9'h000;
      c_next.strobe = 1'b1; // R17
      c_next.out.left = mix(c_reg.prev.left, c_reg.cur.left,
                            c_reg.phase); // R8
      c_next.out.right = mix(c_reg.prev.right, c_reg.cur.right,
                             c_reg.phase);
      // Hold at last sample if input is late
      c_next.phase = (17'(c_reg.phase) + 17'(SRC_STEP_IN)) > 17'h0ffff ?
        16'hffff : c_reg.phase + SRC_STEP_IN; // R11
    end
  end

  assign SRC_DATA_OUT = c_reg.out;
  assign SRC_STROBE_OUT = c_reg.strobe;

  always_ff @(posedge CLK_SRC_IN) begin
    if (!RESETN_IN) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end
endmodule
`default_nettype wire

// file: bench/bas_serializer_props.sv
`timescale 1ns/10ps
`default_nettype none
module bas_serializer_props #(parameter int BCLK_DIV = 8) (
  // Clocks and reset
  input wire logic CLK_SYS_IN, CLK_SRC_IN, RESETN_IN,
  // Inputs of the block
  input wire bas_pkg::bas_cfg_t CFG_IN,
  input wire logic RX_READY_IN, TX_DMA_ACK_IN, RX_DMA_ACK_IN,
  // Outputs of the block
  input wire bas_pkg::bas_pair_t RX_DATA_OUT,
  input wire logic RX_VALID_OUT, TX_DMA_REQ_OUT, RX_DMA_REQ_OUT, IRQ_OUT,
  input wire logic BCLK_OE_OUT, WCLK_OE_OUT, SDO_OUT, SRC_STROBE_OUT,
  input wire logic SPDIF_OUT
);
  logic [8:0] gap_reg;
  logic seen_reg;
  logic [11:0] mute_reg;
  // Converter cycles since a strobe; the first strobe only arms the check
  always_ff @(posedge CLK_SRC_IN) begin
    if (!RESETN_IN || SRC_STROBE_OUT) gap_reg <= 9'h000;
    else if (gap_reg != 9'h1ff) gap_reg <= gap_reg + 9'h001;
    seen_reg <= RESETN_IN && (seen_reg || SRC_STROBE_OUT);
  end
  // Mute age saturates so a long mute never wraps back to zero
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN || !CFG_IN.mute) mute_reg <= 12'h000;
    else if (mute_reg != 12'hfff) mute_reg <= mute_reg + 12'h001;
  end
  chk_role_oe: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) BCLK_OE_OUT == CFG_IN.master
    && WCLK_OE_OUT == CFG_IN.master) else $error("pin enables vs role");
  chk_spdif_idle: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) (!CFG_IN.master || CFG_IN.gate_bclk) [*3]
    |-> !SPDIF_OUT) else $error("line output active while not allowed");
  chk_irq_pulse: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) IRQ_OUT |=> !IRQ_OUT)
    else $error("interrupt longer than one cycle");
  chk_rx_hold: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) RX_VALID_OUT && !RX_READY_IN
    && !CFG_IN.soft_reset |=> RX_VALID_OUT && $stable(RX_DATA_OUT))
    else $error("receive pair lost under stall");
  chk_txreq_hold: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) TX_DMA_REQ_OUT && !TX_DMA_ACK_IN
    && !CFG_IN.soft_reset |=> TX_DMA_REQ_OUT) else $error("tx req dropped");
  chk_rxreq_hold: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) RX_DMA_REQ_OUT && !RX_DMA_ACK_IN
    && !CFG_IN.soft_reset |=> RX_DMA_REQ_OUT) else $error("rx req dropped");
  chk_src_period: assert property (@(posedge CLK_SRC_IN)
    disable iff (!RESETN_IN) seen_reg |-> (SRC_STROBE_OUT ?
    gap_reg == 9'h17f : gap_reg < 9'h17f)) else $error("converter period");
  chk_mute_quiet: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) mute_reg >= 12'(256 * BCLK_DIV) |-> !SDO_OUT)
    else $error("serial data while muted");
endmodule
bind bas_serializer bas_serializer_props #(.BCLK_DIV(BCLK_DIV))
  bas_serializer_props_inst (.CLK_SYS_IN, .CLK_SRC_IN, .RESETN_IN, .CFG_IN,
  .RX_READY_IN, .TX_DMA_ACK_IN, .RX_DMA_ACK_IN, .RX_DATA_OUT, .RX_VALID_OUT,
  .TX_DMA_REQ_OUT, .RX_DMA_REQ_OUT, .IRQ_OUT, .BCLK_OE_OUT, .WCLK_OE_OUT,
  .SDO_OUT, .SRC_STROBE_OUT, .SPDIF_OUT);
`default_nettype wire

// file: bench/bas_audio_partner.sv
`timescale 1ns/10ps
`default_nettype none
module bas_audio_partner (
  // Far side serial pins
  input wire logic sdo_in,
  input wire logic slave_in,
  output logic bclk_out,
  output logic wclk_out,
  output logic sdi_out
);
  int bits = 0;
  initial bclk_out = 1'b0;
  initial wclk_out = 1'b0;
  // Bit clock runs only while the device is slave, else it stands low
  always #200 bclk_out = slave_in ? ~bclk_out : 1'b0;
  // Fixed 32 bits per slot, so the device must be set to 32-bit words
  always @(negedge bclk_out) begin
    bits <= (bits + 1) % 32;
    if (bits == 31) wclk_out <= ~wclk_out;
  end
  // Echo what the device sends straight back
  assign sdi_out = sdo_in;
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  logic clk = 1'b0, clk_src = 1'b0, rst_n = 1'b0, hold_rx = 1'b0;
  logic valid = 1'b0, ready, rx_valid, rx_ready = 1'b1, user_bit = 1'b0;
  logic tx_req, rx_req, tx_ack = 1'b0, rx_ack = 1'b0, sdo, sdi, src_stb;
  logic irq, spdif, spdif_d, bclk_m, wclk_m, bclk_s, wclk_s, bclk_oe, wclk_oe;
  wire logic bclk_w, wclk_w;
  logic [15:0] step = 16'h0000;
  logic [31:0] seed = 32'h08e3_d03f, r;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  logic [1:0] frozen;
  bas_pkg::bas_cfg_t cfg;
  bas_pkg::bas_pair_t tx_data, rx_data, src_data;
  int miscompares = 0, check_count = 0, cycles = 0, irqs = 0, edges = 0;
  // Clocks unrelated in phase
  always #12.5 clk = ~clk;
  always #24 clk_src = ~clk_src;
  // Shared clock wires resolved from both drivers
  assign bclk_w = bclk_oe ? bclk_m : bclk_s;
  assign wclk_w = wclk_oe ? wclk_m : wclk_s;
  bas_serializer #(.FIFO_DEPTH(2), .BCLK_DIV(8)) bas_serializer_inst (
    .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .CLK_SRC_IN(clk_src), .CFG_IN(cfg),
    .SRC_STEP_IN(step), .USER_BIT_IN(user_bit), .TX_DATA_IN(tx_data),
    .TX_VALID_IN(valid), .TX_READY_OUT(ready), .RX_DATA_OUT(rx_data),
    .RX_VALID_OUT(rx_valid), .RX_READY_IN(rx_ready), .TX_DMA_REQ_OUT(tx_req),
    .TX_DMA_ACK_IN(tx_ack), .RX_DMA_REQ_OUT(rx_req), .RX_DMA_ACK_IN(rx_ack),
    .IRQ_OUT(irq), .BCLK_IN(bclk_w), .WCLK_IN(wclk_w), .SDI_IN(sdi),
    .BCLK_OUT(bclk_m), .BCLK_OE_OUT(bclk_oe), .WCLK_OUT(wclk_m),
    .WCLK_OE_OUT(wclk_oe), .SDO_OUT(sdo), .SRC_DATA_OUT(src_data),
    .SRC_STROBE_OUT(src_stb), .SPDIF_OUT(spdif));
  bas_audio_partner bas_audio_partner_inst (.sdo_in(sdo),
    .slave_in(!cfg.master), .bclk_out(bclk_s), .wclk_out(wclk_s),
    .sdi_out(sdi));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Random stalls, DMA answers and side inputs, off the sampling edge
  always @(negedge clk) begin
    r = rnd();
    rx_ready <= !hold_rx && r[0];
    tx_ack <= tx_req && r[1];
    rx_ack <= rx_req && r[2];
    user_bit <= r[3];
    step <= r[31:16];
  end
  // Scoreboard; zero pairs are idle frames and carry no traffic
  always @(posedge clk) begin
    cycles++;
    spdif_d <= spdif;
    if (spdif !== spdif_d) edges++;
    if (irq) irqs++;
    if (rst_n && rx_valid && rx_ready && rx_data !== 64'h0) begin
      e = exp_q.size() ? exp_q.pop_front() : 65'h0;
      `CHK(e[64] ? {rx_data.left, 32'h0} : rx_data, e[64] ? {e[63:32], 32'h0} : e[63:0])
    end
    if (cycles == 60000) begin
      miscompares++;
      give_verdict();
    end
  end
  // Offer one random pair and hold it until taken
  task automatic send(input logic mono, input logic keep);
    bas_pkg::bas_pair_t p;
    p = {rnd(), rnd()};
    tx_data <= p;
    valid <= 1'b1;
    if (keep) exp_q.push_back({mono, p});
    while (!ready) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic idle(input int n);
    valid <= 1'b0;
    repeat (n) @(negedge clk);
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    cfg = '{master: 1'b1, wlen: bas_pkg::BAS_WL_32, stereo: 1'b1,
      default: 1'b0};
    tx_data = 64'h0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    idle(3000);
    repeat (4) send(1'b0, 1'b1);
    idle(5000);
    `CHK(edges > 0, 1'b1)
    // Stop freezes the serial state while the bit clock keeps running
    cfg.stop = 1'b1;
    idle(50);
    frozen = {sdo, wclk_m};
    idle(2000);
    `CHK({sdo, wclk_m}, frozen)
    cfg.stop = 1'b0;
    $display("stereo done");
    // Two words fill transmit mid-frame; held receive then overflows
    @(posedge wclk_m);
    @(negedge clk);
    send(1'b0, 1'b1);
    send(1'b0, 1'b1);
    `CHK(ready, 1'b0)
    idle(1);
    while (!ready) @(negedge clk);
    idle(20);
    hold_rx <= 1'b1;
    while (irqs == 0) @(negedge clk);
    hold_rx <= 1'b0;
    `CHK(irqs, 1)
    idle(3000);
    $display("fill done");
    cfg.stereo = 1'b0;
    cfg.double_speed = 1'b1;
    idle(2000);
    send(1'b1, 1'b1);
    idle(3000);
    $display("mono done");
    // Muted pair comes back silent, so nothing is expected
    cfg = '{master: 1'b1, wlen: bas_pkg::BAS_WL_16, stereo: 1'b1,
      mute: 1'b1, default: 1'b0};
    idle(200);
    send(1'b0, 1'b0);
    idle(3000);
    cfg.mute = 1'b0;
    cfg.gate_bclk = 1'b1;
    cfg.wlen = bas_pkg::BAS_WL_8;
    idle(1000);
    cfg.gate_bclk = 1'b0;
    cfg.wlen = bas_pkg::BAS_WL_32;
    idle(2000);
    $display("mute done");
    cfg.master = 1'b0;
    idle(3000);
    send(1'b0, 1'b1);
    idle(5000);
    $display("slave done");
    cfg.soft_reset = 1'b1;
    idle(2);
    `CHK(ready, 1'b1)
    `CHK(rx_valid, 1'b0)
    cfg.soft_reset = 1'b0;
    `CHK(exp_q.size(), 0)
    give_verdict();
  end
endmodule
`default_nettype wire
